/* File: common/timer_input_capture_defines.svh */
`ifndef TIMER_INPUT_CAPTURE_DEFINES_SVH
`define TIMER_INPUT_CAPTURE_DEFINES_SVH

// register offsets (byte addresses on the local port)
`define REG_ADDR_W     6
`define FLG1_OFF       6'h00
`define EN1_OFF        6'h01
`define FLG2_OFF       6'h02
`define EN2_OFF        6'h03
`define EDGE_OFF       6'h04
`define CAP_BASE_OFF   6'h10

// field positions in timer_flag_reg_two
`define OVF_BIT        7
`define TICK_BIT       6

// reset values
`define EN_RST         8'h00
`define EDGE_RST       8'h00

// compare output pipeline depth, in clock cycles
`define SYNC_STAGES    2

`endif

/* File: common/timer_input_capture_pkg.sv */
`include "timer_input_capture_defines.svh"

package timer_input_capture_pkg;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_mode_t;

  typedef struct packed {
    logic [`REG_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   wr;
    logic                   rd;
  } reg_req_t;

endpackage

/* File: hw/timer_input_capture.sv */
// Local design decisions: the placing of the registers and the address-and-strobe port.
`include "timer_input_capture_defines.svh"

// What this block does
// - channel latches counter on selected pin edge
// - three channels, rise, fall or both edges
// - edge sets flag; enable gates interrupt request
// - latch stable counter, never mid-increment
// - identical pin-to-detect delay for every edge
// - capture read as high and low bytes
// - capture regs unreset, writes ignored
// - both bytes loaded in one transfer
// - flag registers clear bits written with one
// - compare output has matching synchroniser delay
// - writing zero leaves set flag alone
// - high-byte read delays capture one cycle
// - latch on every edge even if flagged
module timer_input_capture #(
  parameter int NUM_CH = 3
) (
  // clock and reset
  input  wire logic                              clk_sys_in,
  input  wire logic                              nrst_in,
  // register port
  input  wire timer_input_capture_pkg::reg_req_t req_in,
  output logic [7:0]                             rd_data_out,
  // timer core
  input  wire logic [15:0]                       count_in,
  input  wire logic                              ovf_event_in,
  input  wire logic                              tick_event_in,
  input  wire logic                              oc_match_in,
  input  wire logic                              oc_level_in,
  // pins
  input  wire logic [NUM_CH-1:0]                 cap_pin_in,
  output logic                                   oc_pin_out,
  // interrupt
  output logic                                   irq_out
);

  function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
    logic r;
    r = 1'b0;
    unique case (timer_input_capture_pkg::edge_mode_t'(mode))
      timer_input_capture_pkg::EDGE_NONE: r = 1'b0;
      timer_input_capture_pkg::EDGE_RISE: r = cur & ~prev;
      timer_input_capture_pkg::EDGE_FALL: r = prev & ~cur;
      timer_input_capture_pkg::EDGE_BOTH: r = cur ^ prev;
    endcase
    return r;
  endfunction

  function automatic logic is_cap_byte(input logic [`REG_ADDR_W-1:0] a, input int ch, input logic hi);
    return a == (`CAP_BASE_OFF + `REG_ADDR_W'(2 * ch) + (hi ? `REG_ADDR_W'(0) : `REG_ADDR_W'(1)));
  endfunction

  logic [NUM_CH-1:0] sync1_reg;
  logic [NUM_CH-1:0] sync2_reg;
  logic [NUM_CH-1:0] prev_reg;
  logic [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0] hold_reg;
  logic [NUM_CH-1:0] pend_reg;
  logic [NUM_CH-1:0] take;
  logic [NUM_CH-1:0] rd_hi;
  logic [15:0]       pend_val_reg [NUM_CH];
  logic [15:0]       take_val     [NUM_CH];
  logic [15:0]       cap_val_reg  [NUM_CH];
  logic [NUM_CH-1:0] flag1_reg;
  logic [NUM_CH-1:0] flag1_next;
  logic [1:0]        flag2_reg;
  logic [1:0]        flag2_next;
  logic [NUM_CH-1:0] en1_reg;
  logic [1:0]        en2_reg;
  logic [7:0]        edge_reg;
  logic [7:0]        rd_mux;
  logic [`SYNC_STAGES-1:0] oc_match_pipe_reg;
  logic [`SYNC_STAGES-1:0] oc_level_pipe_reg;
  logic              wr_flg1;
  logic              wr_flg2;

  assign wr_flg1 = req_in.wr && req_in.addr == `FLG1_OFF;
  assign wr_flg2 = req_in.wr && req_in.addr == `FLG2_OFF;

  // first stage feeds only the second
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end
    else
    begin
      sync1_reg <= cap_pin_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  generate
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ch
      // compare successive synchronised samples
      assign hit[i]      = edge_hit(edge_reg[2*i +: 2], prev_reg[i], sync2_reg[i]);
      assign rd_hi[i]    = req_in.rd && is_cap_byte(req_in.addr, i, 1'b1);
      assign take[i]     = (hit[i] | pend_reg[i]) & ~hold_reg[i];
      // counter comes from a register, so it is settled here
      assign take_val[i] = hit[i] ? count_in : pend_val_reg[i];

      // no reset: contents survive reset, bus writes never land here
      always_ff @(posedge clk_sys_in)
      begin
        if (take[i])
          cap_val_reg[i] <= take_val[i];
      end

      always_ff @(posedge clk_sys_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          hold_reg[i]     <= 1'b0;
          pend_reg[i]     <= 1'b0;
          pend_val_reg[i] <= 16'h0000;
        end
        else
        begin
          hold_reg[i] <= rd_hi[i];
          if (hit[i] && hold_reg[i])
          begin
            pend_reg[i]     <= 1'b1;
            pend_val_reg[i] <= count_in;
          end
          else if (take[i])
            pend_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // hardware set wins over a same-cycle clear
  always_comb
  begin
    flag1_next = flag1_reg;
    flag2_next = flag2_reg;
    if (wr_flg1)
      flag1_next = flag1_reg & ~req_in.wdata[NUM_CH-1:0];
    if (wr_flg2)
      flag2_next = flag2_reg & ~req_in.wdata[`OVF_BIT:`TICK_BIT];
    flag1_next = flag1_next | hit;
    flag2_next = flag2_next | {ovf_event_in, tick_event_in};
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      flag1_reg <= '0;
      flag2_reg <= '0;
    end
    else
    begin
      flag1_reg <= flag1_next;
      flag2_reg <= flag2_next;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      en1_reg  <= NUM_CH'(`EN_RST);
      en2_reg  <= 2'(`EN_RST);
      edge_reg <= `EDGE_RST;
    end
    else if (req_in.wr)
    begin
      if (req_in.addr == `EN1_OFF)
        en1_reg <= req_in.wdata[NUM_CH-1:0];
      if (req_in.addr == `EN2_OFF)
        en2_reg <= req_in.wdata[`OVF_BIT:`TICK_BIT];
      if (req_in.addr == `EDGE_OFF)
        edge_reg <= req_in.wdata;
    end
  end

  // enables gate only the request, never the flags
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(flag1_reg & en1_reg) | |(flag2_reg & en2_reg);
  end

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (req_in.addr)
      `FLG1_OFF: rd_mux = 8'(flag1_reg);
      `EN1_OFF:  rd_mux = 8'(en1_reg);
      `FLG2_OFF: rd_mux = {flag2_reg, 6'h00};
      `EN2_OFF:  rd_mux = {en2_reg, 6'h00};
      `EDGE_OFF: rd_mux = edge_reg;
      default:   rd_mux = 8'h00;
    endcase
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (is_cap_byte(req_in.addr, i, 1'b1))
        rd_mux = cap_val_reg[i][15:8];
      if (is_cap_byte(req_in.addr, i, 1'b0))
        rd_mux = cap_val_reg[i][7:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rd_data_out <= 8'h00;
    else
      rd_data_out <= req_in.rd ? rd_mux : 8'h00;
  end

  // same depth as the capture path keeps compare and capture aligned
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      oc_match_pipe_reg <= '0;
      oc_level_pipe_reg <= '0;
      oc_pin_out        <= 1'b0;
    end
    else
    begin
      oc_match_pipe_reg <= {oc_match_pipe_reg[`SYNC_STAGES-2:0], oc_match_in};
      oc_level_pipe_reg <= {oc_level_pipe_reg[`SYNC_STAGES-2:0], oc_level_in};
      if (oc_match_pipe_reg[`SYNC_STAGES-1])
        oc_pin_out <= oc_level_pipe_reg[`SYNC_STAGES-1];
    end
  end

  property p_cap_on_edge;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    hit[0] && !hold_reg[0] |=> cap_val_reg[0] == $past(count_in);
  endproperty
  a_cap_on_edge: assert property (p_cap_on_edge)
    else $error("capture did not latch counter on edge");

  property p_mode_off;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    edge_reg[1:0] == 2'h0 |-> !hit[0] ##1 $stable(flag1_reg[0]) || wr_flg1 || !flag1_reg[0];
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("edge detected with channel disabled");

  property p_flag_irq;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    hit[0] && en1_reg[0] && !req_in.wr |=> flag1_reg[0] ##1 irq_out;
  endproperty
  a_flag_irq: assert property (p_flag_irq)
    else $error("flag or interrupt missing after edge");

  property p_fixed_delay;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    edge_reg[1:0] == 2'h1 && $past(edge_reg[1:0]) == 2'h1 |->
      hit[0] == ($past(cap_pin_in[0], 2) && !$past(cap_pin_in[0], 3));
  endproperty
  a_fixed_delay: assert property (p_fixed_delay)
    else $error("pin to detect delay not fixed");

  property p_read_hi;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    rd_hi[1] |=> rd_data_out == $past(cap_val_reg[1][15:8]);
  endproperty
  a_read_hi: assert property (p_read_hi)
    else $error("high byte read returned wrong data");

  property p_write_ignored;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    req_in.wr && req_in.addr == `CAP_BASE_OFF && !take[0] |=> $stable(cap_val_reg[0]);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("bus write altered capture register");

  property p_whole_transfer;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    take[1] |=> cap_val_reg[1] == $past(take_val[1]);
  endproperty
  a_whole_transfer: assert property (p_whole_transfer)
    else $error("capture transfer not a single 16-bit load");

  property p_clear_one;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    wr_flg1 && req_in.wdata[0] && !hit[0] |=> !flag1_reg[0];
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("written one did not clear flag");

  property p_zero_keeps;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    flag2_reg[1] && wr_flg2 && !req_in.wdata[`OVF_BIT] |=> flag2_reg[1];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("written zero cleared a flag");

  property p_hold_delay;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    hold_reg[0] && hit[0] && !rd_hi[0] ##1 !hit[0] |-> $stable(cap_val_reg[0]) && pend_reg[0]
      ##1 cap_val_reg[0] == $past(count_in, 2);
  endproperty
  a_hold_delay: assert property (p_hold_delay)
    else $error("held capture lost or not delayed one cycle");

  property p_relatch;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    flag1_reg[2] && hit[2] && !hold_reg[2] |=> cap_val_reg[2] == $past(count_in);
  endproperty
  a_relatch: assert property (p_relatch)
    else $error("no recapture while flag set");

  property p_oc_delay;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    oc_match_in ##1 !oc_match_in [*2] |=> oc_pin_out == $past(oc_level_in, 3);
  endproperty
  a_oc_delay: assert property (p_oc_delay)
    else $error("compare output delay wrong");

  property p_read_idle;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !req_in.rd |=> rd_data_out == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data not cleared outside a read");

  property p_irq_idle;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !(|(flag1_reg & en1_reg)) && !(|(flag2_reg & en2_reg)) |=> !irq_out;
  endproperty
  a_irq_idle: assert property (p_irq_idle)
    else $error("interrupt raised with no enabled flag");

endmodule

/* File: tb/timer_core_model.sv */
module timer_core_model (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  // counter
  output logic      [15:0] count_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // free-running count, changes only at the rising edge
  always_ff @(posedge clk_sys_in or negedge nrst_in)
    if (!nrst_in)
      count_out <= 16'h0000;
    else
      count_out <= count_out + 16'h0001;
endmodule

/* File: tb/testbench.sv */
`include "timer_input_capture_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                              clk_sys_in = 1'b0;
  logic                              nrst_in    = 1'b0;
  timer_input_capture_pkg::reg_req_t req        = '0;
  logic                       [7:0]  rd_data;
  logic                       [15:0] count;
  logic                       [15:0] c0;
  logic                       [2:0]  pins       = 3'h0;
  logic                              ovf_ev     = 1'b0;
  logic                              tick_ev    = 1'b0;
  logic                              oc_match   = 1'b0;
  logic                              oc_level   = 1'b0;
  logic                              oc_pin;
  logic                              irq;
  int                                mismatches = 0;
  int                                n_checks   = 0;
  int                                cycles     = 0;

  always #10 clk_sys_in = ~clk_sys_in;

  timer_core_model i_timer_core_model (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .count_out  (count)
  );

  timer_input_capture i_timer_input_capture (
    .clk_sys_in    (clk_sys_in),
    .nrst_in       (nrst_in),
    .req_in        (req),
    .rd_data_out   (rd_data),
    .count_in      (count),
    .ovf_event_in  (ovf_ev),
    .tick_event_in (tick_ev),
    .oc_match_in   (oc_match),
    .oc_level_in   (oc_level),
    .cap_pin_in    (pins),
    .oc_pin_out    (oc_pin),
    .irq_out       (irq)
  );

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    req <= '0;
  endtask

  // data is only valid in the cycle after the strobe edge
  task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    req <= '0;
    @(negedge clk_sys_in);
    chk(what, {8'h00, exp}, {8'h00, rd_data});
  endtask

  // c0 holds the count seen in the cycle the pins change
  task automatic pin_to(input logic [2:0] v);
    @(posedge clk_sys_in);
    pins <= v;
    @(negedge clk_sys_in);
    c0 = count;
  endtask

  task automatic t_reset();
    for (int a = 0; a < 5; a++)
      rd(6'(a), 8'h00, "reset reg");
    rd(6'h3F, 8'h00, "unmapped");
    chk("irq", 16'h0000, {15'h0, irq});
  endtask

  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      wr(`EDGE_OFF, 8'({2'(m), 2'(m), 2'(m)}));
      pin_to(3'h7);
      repeat (4) @(posedge clk_sys_in);
      rd(`FLG1_OFF, m[0] ? 8'h07 : 8'h00, "rise flags");
      wr(`FLG1_OFF, 8'h07);
      pin_to(3'h0);
      repeat (4) @(posedge clk_sys_in);
      rd(`FLG1_OFF, m[1] ? 8'h07 : 8'h00, "fall flags");
      wr(`FLG1_OFF, 8'h07);
    end
  endtask

  task automatic t_capture();
    logic [15:0] exp;
    logic [15:0] nxt;
    wr(`EDGE_OFF, 8'h3F);
    wr(`EN1_OFF, 8'h01);
    pin_to(3'h7);
    exp = c0 + 16'h0002;
    repeat (3) @(negedge clk_sys_in);
    chk("irq early", 16'h0000, {15'h0, irq});
    @(negedge clk_sys_in);
    chk("irq", 16'h0001, {15'h0, irq});
    rd(`CAP_BASE_OFF, exp[15:8], "cap high");
    rd(`CAP_BASE_OFF + 6'h01, exp[7:0], "cap low");
    // edges in one count cycle give every channel the same value
    rd(`CAP_BASE_OFF + 6'h02, exp[15:8], "cap1 high");
    rd(`CAP_BASE_OFF + 6'h05, exp[7:0], "cap2 low");
    wr(`CAP_BASE_OFF, 8'hFF);
    rd(`CAP_BASE_OFF, exp[15:8], "cap after write");
    // flags still set here, the falling edges must recapture
    pin_to(3'h2);
    exp = c0 + 16'h0002;
    repeat (4) @(posedge clk_sys_in);
    rd(`CAP_BASE_OFF, exp[15:8], "recap high");
    rd(`CAP_BASE_OFF + 6'h01, exp[7:0], "recap low");
    rd(`CAP_BASE_OFF + 6'h05, exp[7:0], "recap2 low");
    // edge falls in the cycle after the high-byte strobe, low byte must still pair
    pin_to(3'h3);
    nxt = c0 + 16'h0002;
    rd(`CAP_BASE_OFF, exp[15:8], "held high");
    rd(`CAP_BASE_OFF + 6'h01, exp[7:0], "held low");
    rd(`CAP_BASE_OFF + 6'h01, nxt[7:0], "late low");
    wr(`EN1_OFF, 8'h00);
    repeat (2) @(negedge clk_sys_in);
    chk("irq masked", 16'h0000, {15'h0, irq});
    rd(`FLG1_OFF, 8'h07, "polled flag");
    wr(`FLG1_OFF, 8'h07);
    // a reset in mid-run must leave the capture registers alone
    @(posedge clk_sys_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rd(`CAP_BASE_OFF + 6'h01, nxt[7:0], "cap kept low");
    rd(`CAP_BASE_OFF + 6'h05, exp[7:0], "cap2 kept low");
  endtask

  task automatic pulse_flags();
    @(posedge clk_sys_in);
    ovf_ev  <= 1'b1;
    tick_ev <= 1'b1;
    @(posedge clk_sys_in);
    ovf_ev  <= 1'b0;
    tick_ev <= 1'b0;
  endtask

  task automatic t_flags2();
    wr(`EN2_OFF, 8'h80);
    pulse_flags();
    repeat (3) @(negedge clk_sys_in);
    chk("irq ovf", 16'h0001, {15'h0, irq});
    rd(`FLG2_OFF, 8'hC0, "flag2");
    wr(`FLG2_OFF, 8'h00);
    rd(`FLG2_OFF, 8'hC0, "flag2 zero write");
    wr(`FLG2_OFF, 8'h80);
    rd(`FLG2_OFF, 8'h40, "flag2 ovf only");
    repeat (2) @(negedge clk_sys_in);
    chk("irq tick masked", 16'h0000, {15'h0, irq});
    pulse_flags();
    // write back what was read, as a set-bit instruction would
    wr(`FLG2_OFF, 8'hC0);
    rd(`FLG2_OFF, 8'h00, "flag2 rmw");
  endtask

  task automatic t_compare();
    @(posedge clk_sys_in);
    oc_match <= 1'b1;
    oc_level <= 1'b1;
    @(posedge clk_sys_in);
    oc_match <= 1'b0;
    // first negedge here is already in the cycle the match is sampled
    repeat (2) @(negedge clk_sys_in);
    chk("oc early", 16'h0000, {15'h0, oc_pin});
    @(negedge clk_sys_in);
    chk("oc pin", 16'h0001, {15'h0, oc_pin});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      conclude();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    t_reset();
    t_modes();
    t_capture();
    t_flags2();
    t_compare();
    conclude();
  end
endmodule
